/* rtl/icmc_map.svh */
`ifndef ICMC_MAP_SVH
`define ICMC_MAP_SVH
// system clock rate
`define ICMC_MCLK_MHZ 20
// interrupt input glitch rejection, least stable times
`define ICMC_IRQ_LOW_NS 1000
`define ICMC_IRQ_HIGH_NS 500
`define ICMC_IRQ_LOW_CYC ((`ICMC_IRQ_LOW_NS * `ICMC_MCLK_MHZ + 999) / 1000)
`define ICMC_IRQ_HIGH_CYC ((`ICMC_IRQ_HIGH_NS * `ICMC_MCLK_MHZ + 999) / 1000)
// master serial clock quarter period, rounded down
`define ICMC_SCL_QTR_NS 625
`define ICMC_SCL_QTR_CYC ((`ICMC_SCL_QTR_NS * `ICMC_MCLK_MHZ) / 1000)
// control register layout and reset
`define ICMC_CTRL_RESET 3'h0
`define ICMC_CTRL_EN_BIT 2
`define ICMC_ADDR_FIXED_DEFAULT 4'h5
// master command port map
`define ICMC_HREG_CMD 2'h0
`define ICMC_HREG_TGT 2'h1
`define ICMC_HREG_STAT 2'h2
`define ICMC_CMD_RW_BIT 8
`define ICMC_HOST_TGT_RESET 7'h28
`endif

/* rtl/icmc_pkg.sv */
package icmc_pkg;
  // target side protocol states
  typedef enum logic [2:0] {
    ICMC_T_IDLE, ICMC_T_ADDR, ICMC_T_ADDR_ACK, ICMC_T_WDATA, ICMC_T_WDATA_ACK, ICMC_T_RDATA, ICMC_T_RACK
  } icmc_tstate_t;
  // master side sequencer states
  typedef enum logic [1:0] {ICMC_M_IDLE, ICMC_M_START, ICMC_M_BIT, ICMC_M_STOP} icmc_mstate_t;
endpackage : icmc_pkg

/* rtl/icmc_bus_if.sv */
`timescale 1ns/1ps
// upstream two-wire bus; open-drain lines resolved from the enables
interface icmc_bus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // wired-and with pull-up: low only where someone drives low
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport device (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );
  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n
  );
endinterface : icmc_bus_if

/* rtl/icmc_target.sv */
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "icmc_map.svh"
// How it works
// - master sends address right after start
// - last address bit: 1 read, 0 write
// - first byte after address ack stored
// - several bytes: only last one kept
// - control register writable and readable over bus
// - bit 2 enables, bits 1:0 pick channel
// - power-up: all bits zero, nothing connected
// - new selection applies at stop only
// - master sends stop right after ack
// - at most one channel connected
// - any irq input low pulls output low
// - irq seen whether channel connected or not
// - bits 7:4 report channels 3:0
// - irq levels captured when read happens
// - 1 pending, 0 none, any mix
// - indications follow inputs, no latching
// - master polls all devices on flagged channel
// - irq inputs readable as plain inputs
// - low address bits compared with straps
// - ack every received byte when addressed
// - reject short low and high irq pulses
module icmc_target #(
  parameter logic [3:0] ADDR_FIXED = `ICMC_ADDR_FIXED_DEFAULT // fixed upper address bits
) (
  input wire logic mclk, // system clock
  input wire logic rst, // asynchronous reset
  icmc_bus_if.device bus, // upstream serial bus
  input wire logic [2:0] address_strap_pins, // low address bits
  input wire logic [3:0] per_channel_irq_in, // active-low irq inputs
  output logic [3:0] chan_en, // one-hot channel connect
  output logic irq_out_o, // combined irq drive level
  output logic irq_out_oe_n // low while pulling irq low
);
  import icmc_pkg::*;

  localparam logic [4:0] LOW_CYC = 5'(`ICMC_IRQ_LOW_CYC);
  localparam logic [4:0] HIGH_CYC = 5'(`ICMC_IRQ_HIGH_CYC);

  // channel decode, never more than one hot
  function automatic logic [3:0] chan_decode(input logic [2:0] c);
    logic [3:0] oh;
    oh = 4'h0;
    if (c[`ICMC_CTRL_EN_BIT]) begin
      oh[c[1:0]] = 1'b1;
    end
    return oh;
  endfunction : chan_decode

  // read image: pending flags on top, bit 3 zero, selection below
  function automatic logic [7:0] status_byte(input logic [3:0] f, input logic [2:0] c);
    return {~f, 1'b0, c};
  endfunction : status_byte

  // pin synchronisers: [0] scl, [1] sda, [4:2] straps, [8:5] irq
  logic [8:0] meta;
  logic [8:0] sync;
  logic [1:0] prev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= 9'h1ff;
      sync <= 9'h1ff;
      prev <= 2'h3;
    end else begin
      meta <= {per_channel_irq_in, address_strap_pins, bus.sda, bus.scl};
      sync <= meta;
      prev <= sync[1:0];
    end
  end

  // bus events seen on the synchronised copies only
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise = sync[0] & ~prev[0];
  assign scl_fall = ~sync[0] & prev[0];
  assign start_seen = sync[0] & prev[0] & prev[1] & ~sync[1];
  assign stop_seen = sync[0] & prev[0] & ~prev[1] & sync[1];

  // glitch filter per input; works with channel on or off
  logic [3:0] irq_filt;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flt
      logic [4:0] run;
      logic lvl;
      // a change must stand for the full time before it is believed
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          run <= 5'h0;
          lvl <= 1'b1;
        end else if (sync[5 + gi] == lvl) begin
          run <= 5'h0;
        end else if (run == (lvl ? LOW_CYC : HIGH_CYC) - 5'h1) begin
          run <= 5'h0;
          lvl <= sync[5 + gi];
        end else begin
          run <= run + 5'h1;
        end
      end
      assign irq_filt[gi] = lvl;
    end
  endgenerate

  // combined open-drain output, follows the inputs with no latch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_out_oe_n <= 1'b1;
      irq_out_o <= 1'b0;
    end else begin
      irq_out_oe_n <= &irq_filt;
      irq_out_o <= 1'b0;
    end
  end

  // protocol engine
  icmc_tstate_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic rd_mode;
  logic sda_oe_n;
  logic [2:0] pend;
  logic pend_v;
  logic [2:0] ctrl;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ICMC_T_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      rd_mode <= 1'b0;
      sda_oe_n <= 1'b1;
      pend <= 3'h0;
      pend_v <= 1'b0;
    end else if (stop_seen) begin
      state <= ICMC_T_IDLE;
      sda_oe_n <= 1'b1;
      pend_v <= 1'b0;
    end else if (start_seen) begin
      state <= ICMC_T_ADDR;
      cnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (scl_rise) begin
      case (state)
        ICMC_T_ADDR, ICMC_T_WDATA: begin
          shreg <= {shreg[6:0], sync[1]};
          cnt <= cnt + 4'h1;
        end
        // master nack ends the read; ack asks for another copy
        ICMC_T_RACK: if (sync[1]) state <= ICMC_T_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state)
        ICMC_T_ADDR: if (cnt == 4'h8) begin
          if (shreg[7:1] == {ADDR_FIXED, sync[4:2]}) begin
            state <= ICMC_T_ADDR_ACK;
            sda_oe_n <= 1'b0;
            rd_mode <= shreg[0];
          end else begin
            state <= ICMC_T_IDLE;
          end
        end
        ICMC_T_WDATA: if (cnt == 4'h8) begin
          pend <= shreg[2:0];
          pend_v <= 1'b1;
          state <= ICMC_T_WDATA_ACK;
          sda_oe_n <= 1'b0;
        end
        ICMC_T_ADDR_ACK, ICMC_T_RACK: begin
          if (rd_mode) begin
            shreg <= status_byte(irq_filt, ctrl);
            sda_oe_n <= status_byte(irq_filt, ctrl) >> 7 != 8'h00;
            cnt <= 4'h1;
            state <= ICMC_T_RDATA;
          end else begin
            sda_oe_n <= 1'b1;
            cnt <= 4'h0;
            state <= ICMC_T_WDATA;
          end
        end
        ICMC_T_WDATA_ACK: begin
          sda_oe_n <= 1'b1;
          cnt <= 4'h0;
          state <= ICMC_T_WDATA;
        end
        ICMC_T_RDATA: begin
          if (cnt == 4'h8) begin
            sda_oe_n <= 1'b1;
            state <= ICMC_T_RACK;
          end else begin
            shreg <= {shreg[6:0], 1'b1};
            sda_oe_n <= shreg[6];
            cnt <= cnt + 4'h1;
          end
        end
        default: ;
      endcase
    end
  end

  // selection moves only at stop, so lines are idle when switched
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= `ICMC_CTRL_RESET;
    end else if (stop_seen && pend_v) begin
      ctrl <= pend;
    end
  end

  // one-hot connect outputs from a flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chan_en <= 4'h0;
    end else begin
      chan_en <= chan_decode(ctrl);
    end
  end

  // open-drain data pin; level held low, enable does the work
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.dev_sda_o <= 1'b0;
      bus.dev_sda_oe_n <= 1'b1;
    end else begin
      bus.dev_sda_o <= 1'b0;
      bus.dev_sda_oe_n <= sda_oe_n;
    end
  end

  // limitation: no clock stretching, the master's pace is trusted
  // trade-off: irq flags reach the read byte only after filtering,
  // so a read can lag the pins by up to the rejection time
endmodule : icmc_target

/* rtl/icmc_master.sv */
`timescale 1ns/1ps
`include "icmc_map.svh"
module icmc_master (
  input wire logic mclk, // system clock
  input wire logic rst, // asynchronous reset
  icmc_bus_if.host bus, // upstream serial bus
  input wire logic [1:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata // read data, cycle after strobe
);
  import icmc_pkg::*;

  localparam logic [3:0] QCYC = 4'(`ICMC_SCL_QTR_CYC);

  // data pin synchroniser, first flop feeds only the second
  logic sda_meta;
  logic sda_in;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_meta <= 1'b1;
      sda_in <= 1'b1;
    end else begin
      sda_meta <= bus.sda;
      sda_in <= sda_meta;
    end
  end

  icmc_mstate_t state;
  logic [3:0] qcnt;
  logic tick;
  assign tick = (qcnt == QCYC - 4'h1);

  // quarter-period divider, the bus clock is built from it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      qcnt <= 4'h0;
    end else if (state == ICMC_M_IDLE || tick) begin
      qcnt <= 4'h0;
    end else begin
      qcnt <= qcnt + 4'h1;
    end
  end

  logic [6:0] tgt;
  logic [7:0] wbyte;
  logic rw;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic byte1;
  logic [8:0] tx;
  logic [7:0] rx;
  logic [7:0] rbyte;
  logic nack;
  logic scl_oe_n;
  logic sda_oe_n;

  // target address register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tgt <= `ICMC_HOST_TGT_RESET;
    end else if (reg_wr && reg_addr == `ICMC_HREG_TGT) begin
      tgt <= reg_wdata[6:0];
    end
  end

  // sequencer: start, address byte, one data byte, stop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ICMC_M_IDLE;
      wbyte <= 8'h00;
      rw <= 1'b0;
      ph <= 2'h0;
      bitn <= 4'h0;
      byte1 <= 1'b0;
      tx <= 9'h1ff;
      rx <= 8'h00;
      rbyte <= 8'h00;
      nack <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (state == ICMC_M_IDLE) begin
      // commands while busy are dropped
      if (reg_wr && reg_addr == `ICMC_HREG_CMD) begin
        rw <= reg_wdata[`ICMC_CMD_RW_BIT];
        wbyte <= reg_wdata[7:0];
        tx <= {tgt, reg_wdata[`ICMC_CMD_RW_BIT], 1'b1};
        nack <= 1'b0;
        ph <= 2'h0;
        state <= ICMC_M_START;
      end
    end else if (tick) begin
      ph <= ph + 2'h1;
      case (state)
        ICMC_M_START: begin
          if (ph == 2'h2) sda_oe_n <= 1'b0;
          if (ph == 2'h3) begin
            scl_oe_n <= 1'b0;
            bitn <= 4'h0;
            byte1 <= 1'b0;
            state <= ICMC_M_BIT;
          end
        end
        ICMC_M_BIT: begin
          case (ph)
            2'h0: sda_oe_n <= tx[8];
            2'h1: scl_oe_n <= 1'b1;
            2'h2: begin
              if (bitn != 4'h8) rx <= {rx[6:0], sda_in};
              else if (!(byte1 && rw)) nack <= sda_in;
            end
            default: begin
              scl_oe_n <= 1'b0;
              tx <= {tx[7:0], 1'b1};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                if (byte1 || nack) begin
                  state <= ICMC_M_STOP;
                end else begin
                  byte1 <= 1'b1;
                  tx <= rw ? 9'h1ff : {wbyte, 1'b1};
                end
              end
            end
          endcase
        end
        ICMC_M_STOP: begin
          case (ph)
            2'h0: sda_oe_n <= 1'b0;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: sda_oe_n <= 1'b1;
            default: begin
              if (rw && !nack) rbyte <= rx;
              state <= ICMC_M_IDLE;
            end
          endcase
        end
        default: state <= ICMC_M_IDLE;
      endcase
    end
  end

  // open-drain pins, enable low while pulling low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.host_scl_o <= 1'b0;
      bus.host_sda_o <= 1'b0;
    end else begin
      bus.host_scl_o <= 1'b0;
      bus.host_sda_o <= 1'b0;
    end
  end
  assign bus.host_scl_oe_n = scl_oe_n;
  assign bus.host_sda_oe_n = sda_oe_n;

  // read port, data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ICMC_HREG_CMD: reg_rdata <= {7'h00, rw, wbyte};
        `ICMC_HREG_TGT: reg_rdata <= {9'h000, tgt};
        `ICMC_HREG_STAT: reg_rdata <= {rbyte, 6'h00, nack, state != ICMC_M_IDLE};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : icmc_master

/* tb/icmc_link_chk.sv */
`timescale 1ns/1ps
// watches the upstream two-wire link where both ends are design code
module icmc_link_chk (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset
  input wire logic host_scl_oe_n, // master clock pull
  input wire logic host_sda_oe_n, // master data pull
  input wire logic dev_sda_o, // target data level
  input wire logic dev_sda_oe_n, // target data pull
  input wire logic scl, // resolved clock
  input wire logic sda // resolved data
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // every line let go as reset ends
  idle_release_a: assert property ($fell(rst) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
    else $error("line held after reset");
  // open drain: a driving target really pulls the wire low
  dev_pull_low_a: assert property (!dev_sda_oe_n |-> !dev_sda_o && !sda)
    else $error("target drive not low");
  // target moves data only while the clock is low
  dev_scl_low_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("target data moved with clock high");
  // an acknowledge stands for at least 8 cycles after the clock rises
  ack_hold_a: assert property ($rose(scl) && !dev_sda_oe_n |-> !dev_sda_oe_n [*8])
    else $error("ack dropped in high phase");
  // held for at least 8 cycles, then released within 1000 cycles
  dev_bound_a: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8] ##[1:1000] dev_sda_oe_n)
    else $error("target drive length wrong");
  // start conditions belong to the master alone
  start_free_a: assert property (scl && $past(scl) && $fell(sda) |-> dev_sda_oe_n)
    else $error("target held data at start");
  // target has let go when the stop appears
  stop_free_a: assert property (scl && $past(scl) && $rose(sda) |-> dev_sda_oe_n && $past(dev_sda_oe_n))
    else $error("target held data at stop");
  // master clock high phase is never a short pulse while the master pulls data low
  scl_high_a: assert property ($rose(scl) && !host_sda_oe_n |-> scl [*8])
    else $error("clock high phase too short");
endmodule : icmc_link_chk

/* tb/i2c_channel_mux_control_tb.sv */
`timescale 1ns/1ps
module i2c_channel_mux_control_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] straps = 3'h0;
  logic [3:0] irq_n = 4'hf;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0] chan_en;
  logic irq_out_o;
  logic irq_out_oe_n;
  logic [3:0] sel_exp = 4'h0;
  logic [15:0] rv;
  logic glitch = 1'b0;
  logic [3:0] pats [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h6, 4'hf};
  int n_errors = 0;
  int total_checks = 0;
  icmc_bus_if bus ();
  always #25 mclk = ~mclk;
  icmc_target i_icmc_target (.mclk(mclk), .rst(rst), .bus(bus), .address_strap_pins(straps),
    .per_channel_irq_in(irq_n), .chan_en(chan_en), .irq_out_o(irq_out_o), .irq_out_oe_n(irq_out_oe_n));
  icmc_master i_icmc_master (.mclk(mclk), .rst(rst), .bus(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  icmc_link_chk i_icmc_link_chk (.mclk(mclk), .rst(rst), .host_scl_oe_n(bus.host_scl_oe_n),
    .host_sda_oe_n(bus.host_sda_oe_n), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .scl(bus.scl), .sda(bus.sda));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // one link transfer, then poll status until idle; bounded so a hang shows
  task automatic xfer(input logic rd, input logic [7:0] b);
    int n;
    reg_write(2'h0, {7'h00, rd, b});
    n = 0;
    rv = 16'h0001;
    while (rv[0] && n < 3000) begin
      reg_read(2'h2, rv);
      n++;
    end
    check(rv[0], 1'b0);
    repeat (8) @(posedge mclk);
  endtask : xfer
  // selection must not move while the target still acknowledges
  always @(negedge mclk) if (!rst && !bus.dev_sda_oe_n) check(chan_en, sel_exp);
  // hang guard, well above the expected run of about 1.2 ms, inside the cycle budget
  initial begin
    #4_000_000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check(chan_en, 4'h0);
    reg_write(2'h1, 16'h0028);
    reg_read(2'h1, rv);
    check(rv, 16'h0028);
    xfer(1'b1, 8'h00);
    check(rv, 16'h0000);
    // command readback keeps direction and byte of the last order
    reg_read(2'h0, rv);
    check(rv, 16'h0100);
    // every select code, with junk in bit 3 and the upper bits
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, {4'ha, i[0], i[2:0]});
      check(rv[1:0], 2'b00);
      sel_exp = i[2] ? 4'h1 << i[1:0] : 4'h0;
      check(chan_en, sel_exp);
      xfer(1'b1, 8'h00);
      check(rv[15:8], {5'h00, i[2:0]});
    end
    // interrupt patterns with channel 3 connected throughout
    foreach (pats[k]) begin
      @(posedge mclk);
      irq_n <= pats[k];
      repeat (30) @(posedge mclk);
      check({irq_out_o, irq_out_oe_n}, {1'b0, &pats[k]});
      xfer(1'b1, 8'h00);
      check(rv[15:8], {~pats[k], 4'h7});
    end
    // a low pulse of 10 cycles is too short to be believed
    @(posedge mclk);
    irq_n <= 4'h7;
    repeat (10) @(posedge mclk);
    irq_n <= 4'hf;
    repeat (40) begin
      @(posedge mclk);
      if (irq_out_oe_n !== 1'b1) glitch = 1'b1;
    end
    check(glitch, 1'b0);
    // a high pulse of 5 cycles inside a believed low is rejected too
    irq_n <= 4'he;
    repeat (30) @(posedge mclk);
    irq_n <= 4'hf;
    repeat (5) @(posedge mclk);
    irq_n <= 4'he;
    repeat (40) begin
      @(posedge mclk);
      if (irq_out_oe_n !== 1'b0) glitch = 1'b1;
    end
    check(glitch, 1'b0);
    irq_n <= 4'hf;
    repeat (30) @(posedge mclk);
    check(irq_out_oe_n, 1'b1);
    // address follows the straps; the old address is refused
    straps <= 3'h3;
    reg_write(2'h1, 16'h002b);
    xfer(1'b0, 8'h04);
    sel_exp = 4'h1;
    check({rv[1:0], chan_en}, {2'b00, 4'h1});
    reg_write(2'h1, 16'h0028);
    xfer(1'b0, 8'h07);
    check({rv[1:0], chan_en}, {2'b10, 4'h1});
    print_verdict();
  end
endmodule : i2c_channel_mux_control_tb
